// >>> rtl/rcw_defines.svh
`ifndef RCW_DEFINES_SVH
`define RCW_DEFINES_SVH

// Special-function register addresses.
`define RCW_ADDR_WDOG 8'hFF
`define RCW_ADDR_RSTC 8'hEF

// Command bytes written to the watchdog control register.
`define RCW_CMD_RELOAD 8'hA5
`define RCW_CMD_DIS1 8'hDE
`define RCW_CMD_DIS2 8'hAD
`define RCW_CMD_LOCK 8'hFF

// Watchdog control register fields.
`define RCW_WD_SET_BIT 7
`define RCW_WD_RUN_BIT 4
`define RCW_INTV_MSB 2
`define RCW_INTV_RST 3'h7

// Reset cause register bit positions.
`define RCW_RC_RSVD 7
`define RCW_RC_CNV 6
`define RCW_RC_CMP 5
`define RCW_RC_SW 4
`define RCW_RC_WDOG 3
`define RCW_RC_MCD 2
`define RCW_RC_POR 1
`define RCW_RC_PIN 0

// Value that reads back on unmapped addresses and reserved bits.
`define RCW_READ_ZERO 8'h00

// Clock windows and counts.
`define RCW_DIS_WINDOW 3'h4
`define RCW_STRETCH_CYC 4'hC
`define RCW_PIN_DRIVE_CYC 4'hC

// Watchdog counter shape: timeout is 2^(base + 2 * interval) clocks.
`define RCW_WDOG_CNT_W 21
`define RCW_WDOG_BASE_LOG2 6

`endif

// >>> rtl/rcw_pkg.sv
package rcw_pkg;

	// Reset sequencer states.
	typedef enum logic [1:0] {
		rcw_st_run,
		rcw_st_hold,
		rcw_st_stretch
	} rcw_state_t;

	// One register access from the core, valid for a single clock.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rcw_sfr_req_t;

	// Cause of the last reset, in register bit order from bit 6 down.
	typedef struct packed {
		logic convert_start_reset_en_flag;
		logic comparator_reset_en_flag;
		logic software_reset_force_flag;
		logic watchdog_reset_flag;
		logic missing_clock_detect_flag;
		logic power_on_reset_flag;
		logic pin_reset_flag;
	} rcw_cause_t;

endpackage

// >>> rtl/rcw_reset_ctrl.sv
`timescale 1ns/10ps
`include "rcw_defines.svh"

module rcw_reset_ctrl
	import rcw_pkg::*;
#(
	parameter int WDOG_BASE_LOG2 = `RCW_WDOG_BASE_LOG2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire rcw_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	input wire logic convert_start_input,
	input wire logic first_comparator,
	input wire logic missing_clock_trip,
	input wire logic supply_monitor_trip,
	input wire logic supply_monitor_enable_pin,
	output logic sys_rst_b
);

	rcw_state_t state_q; // Reset sequencer state.
	logic [3:0] stretch_q; // Clocks left in the release stretch.
	logic [3:0] drive_q; // Clocks left driving the reset pin low.
	rcw_cause_t cause_q; // Flags of the last reset.
	logic cnv_en_q; // Convert-start input is a reset source.
	logic cmp_en_q; // Comparator output is a reset source.
	logic mcd_en_q; // Missing clock detector is a reset source.
	logic mon_sel_q; // Supply monitor is selected as a reset source.
	logic sw_req_q; // Pending software-forced reset.
	logic por_req_q; // Pending forced power-on reset.
	logic wd_run_q; // Watchdog is counting.
	logic wd_lock_q; // Disable sequence is locked out.
	logic [2:0] wd_intv_q; // Watchdog interval selection.
	logic [2:0] dis_age_q; // Clocks since the first disable byte.
	logic wd_expire; // Watchdog timeout pulse.
	logic in_reset; // System is held in reset.
	logic wr_wdog; // Core writes the watchdog control register.
	logic wr_rstc; // Core writes the reset cause register.
	logic mon_active; // Supply monitor trips while enabled and selected.
	rcw_cause_t src; // Reset sources asserting this clock.
	logic any_src; // At least one source is asserting.

	// Register writes are only taken while the core runs.
	assign in_reset = (state_q != rcw_st_run);
	assign wr_wdog = sfr_req.wr && !in_reset && (sfr_req.addr == `RCW_ADDR_WDOG);
	assign wr_rstc = sfr_req.wr && !in_reset && (sfr_req.addr == `RCW_ADDR_RSTC);

	// The monitor acts only while its enable pin is high and it is selected.
	assign mon_active = supply_monitor_enable_pin && mon_sel_q && supply_monitor_trip;

	// Gather every source that is asserting now.
	always_comb begin
		src = '0;
		src.convert_start_reset_en_flag = cnv_en_q && !convert_start_input;
		src.comparator_reset_en_flag = cmp_en_q && !first_comparator;
		src.software_reset_force_flag = sw_req_q;
		src.watchdog_reset_flag = wd_expire;
		src.missing_clock_detect_flag = mcd_en_q && missing_clock_trip;
		src.power_on_reset_flag = mon_active || por_req_q || (drive_q != 4'h0);
		src.pin_reset_flag = !rst_pin_in;
		any_src = |src;
	end

	// Sequencer: run, hold while a source asserts, then stretch the release.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= rcw_st_stretch;
		end else begin
			case (state_q)
				rcw_st_run: begin
					if (any_src) begin
						state_q <= rcw_st_hold;
					end
				end
				rcw_st_hold: begin
					// Level sources keep the system held until they let go.
					if (!any_src) begin
						state_q <= rcw_st_stretch;
					end
				end
				rcw_st_stretch: begin
					if (any_src) begin
						state_q <= rcw_st_hold;
					end else if (stretch_q == 4'h0) begin
						state_q <= rcw_st_run;
					end
				end
				default: begin
					state_q <= rcw_st_stretch;
				end
			endcase
		end
	end

	// Release stretch counter, reloaded in every state but stretch.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stretch_q <= `RCW_STRETCH_CYC - 4'h1;
		end else if (state_q != rcw_st_stretch) begin
			stretch_q <= `RCW_STRETCH_CYC - 4'h1;
		end else if (stretch_q != 4'h0) begin
			stretch_q <= stretch_q - 4'h1;
		end
	end

	// System reset output, low in every state but run.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_rst_b <= 1'b0;
		end else begin
			sys_rst_b <= (state_q == rcw_st_run) && !any_src;
		end
	end

	// Capture which sources caused this reset at the moment it begins.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cause_q <= '0;
			cause_q.power_on_reset_flag <= 1'b1;
		end else if ((state_q == rcw_st_run) && any_src) begin
			cause_q <= src;
		end
	end

	// Source enables clear at every reset; writes of one arm them.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnv_en_q <= 1'b0;
			cmp_en_q <= 1'b0;
			mcd_en_q <= 1'b0;
		end else if (state_q == rcw_st_stretch) begin
			cnv_en_q <= 1'b0;
			cmp_en_q <= 1'b0;
			mcd_en_q <= 1'b0;
		end else if (wr_rstc) begin
			cnv_en_q <= sfr_req.wdata[`RCW_RC_CNV];
			cmp_en_q <= sfr_req.wdata[`RCW_RC_CMP];
			mcd_en_q <= sfr_req.wdata[`RCW_RC_MCD];
		end
	end

	// Monitor selection is only writable while the enable pin is high.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mon_sel_q <= 1'b1;
		end else if (wr_rstc && supply_monitor_enable_pin) begin
			mon_sel_q <= sfr_req.wdata[`RCW_RC_POR];
		end
	end

	// Forced resets: a write of one raises a one-clock request.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_req_q <= 1'b0;
			por_req_q <= 1'b0;
		end else begin
			sw_req_q <= wr_rstc && sfr_req.wdata[`RCW_RC_SW];
			por_req_q <= wr_rstc && sfr_req.wdata[`RCW_RC_PIN];
		end
	end

	// A forced power-on reset pulls the reset pin low for a fixed time.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_q <= 4'h0;
		end else if (por_req_q) begin
			drive_q <= `RCW_PIN_DRIVE_CYC;
		end else if (drive_q != 4'h0) begin
			drive_q <= drive_q - 4'h1;
		end
	end

	// Open-drain reset pin; the monitor also pulls it during a supply fault.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pin_oe <= 1'b0;
			rst_pin_out <= 1'b0;
		end else begin
			rst_pin_oe <= por_req_q || (drive_q > 4'h1) || mon_active;
			rst_pin_out <= 1'b0;
		end
	end

	// Watchdog run state: restarted by reset or reload, stopped by a disable.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_run_q <= 1'b1;
		end else if (in_reset) begin
			wd_run_q <= 1'b1;
		end else if (wr_wdog && (sfr_req.wdata == `RCW_CMD_RELOAD)) begin
			wd_run_q <= 1'b1;
		end else if (wr_wdog && (sfr_req.wdata == `RCW_CMD_DIS2)) begin
			// Second byte only counts inside the window and without lockout.
			if ((dis_age_q != 3'h0) && !wd_lock_q) begin
				wd_run_q <= 1'b0;
			end
		end
	end

	// Age of the first disable byte; zero means no sequence pending.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dis_age_q <= 3'h0;
		end else if (in_reset) begin
			dis_age_q <= 3'h0;
		end else if (wr_wdog && (sfr_req.wdata == `RCW_CMD_DIS1)) begin
			dis_age_q <= 3'h1;
		end else if (wr_wdog) begin
			dis_age_q <= 3'h0;
		end else if ((dis_age_q != 3'h0) && (dis_age_q < `RCW_DIS_WINDOW)) begin
			dis_age_q <= dis_age_q + 3'h1;
		end else begin
			dis_age_q <= 3'h0;
		end
	end

	// Lockout sticks until the next system reset.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_lock_q <= 1'b0;
		end else if (in_reset) begin
			wd_lock_q <= 1'b0;
		end else if (wr_wdog && (sfr_req.wdata == `RCW_CMD_LOCK)) begin
			wd_lock_q <= 1'b1;
		end
	end

	// Interval is written by any byte with its top bit clear.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_intv_q <= `RCW_INTV_RST;
		end else if (in_reset) begin
			wd_intv_q <= `RCW_INTV_RST;
		end else if (wr_wdog && !sfr_req.wdata[`RCW_WD_SET_BIT]) begin
			wd_intv_q <= sfr_req.wdata[`RCW_INTV_MSB:0];
		end
	end

	// Watchdog counter, restarted by reset and by the reload command.
	rcw_watchdog_timer #(
		.CNT_W(`RCW_WDOG_CNT_W),
		.BASE_LOG2(WDOG_BASE_LOG2)
	) u_watchdog_timer (
		.clk(clk),
		.rst_b(rst_b),
		.hold(in_reset),
		.reload(wr_wdog && (sfr_req.wdata == `RCW_CMD_RELOAD)),
		.run(wd_run_q),
		.interval(wd_intv_q),
		.expire(wd_expire)
	);

	// Read data is registered; unmapped addresses read zero.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sfr_rdata <= `RCW_READ_ZERO;
		end else if (sfr_req.rd) begin
			case (sfr_req.addr)
				`RCW_ADDR_WDOG: begin
					sfr_rdata <= `RCW_READ_ZERO;
					sfr_rdata[`RCW_WD_RUN_BIT] <= wd_run_q;
					sfr_rdata[`RCW_INTV_MSB:0] <= wd_intv_q;
				end
				`RCW_ADDR_RSTC: begin
					// Bit 7 is reserved and always reads zero.
					sfr_rdata <= {1'b0, cause_q};
				end
				default: begin
					sfr_rdata <= `RCW_READ_ZERO;
				end
			endcase
		end
	end

endmodule

// >>> rtl/rcw_watchdog_timer.sv
`timescale 1ns/10ps
`include "rcw_defines.svh"

// Free-running watchdog counter with a programmable terminal count.
module rcw_watchdog_timer
	import rcw_pkg::*;
#(
	parameter int CNT_W = `RCW_WDOG_CNT_W,
	parameter int BASE_LOG2 = `RCW_WDOG_BASE_LOG2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hold,
	input wire logic reload,
	input wire logic run,
	input wire logic [2:0] interval,
	output logic expire
);

	logic [CNT_W-1:0] cnt_q; // Clocks elapsed since the last restart.
	logic [CNT_W-1:0] term; // Last count before the timeout fires.
	int shamt; // Log2 of the timeout length in clocks.

	// The timeout is two to the power of BASE_LOG2 plus twice the interval.
	always_comb begin
		shamt = BASE_LOG2 + 2 * int'(interval);
		term = CNT_W'((32'h0000_0001 << shamt) - 32'h0000_0001);
	end

	// Counter restarts on any system reset or reload command.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (hold || reload) begin
			cnt_q <= '0;
		end else if (run) begin
			if (cnt_q == term) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end
	end

	// One-clock pulse when the count reaches the programmed interval.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			expire <= 1'b0;
		end else begin
			expire <= run && !hold && !reload && (cnt_q == term);
		end
	end

endmodule

// >>> sim/rcw_reset_ctrl_checker.sv
`timescale 1ns/10ps
// Port checks for the reset cause and watchdog controller.
module rcw_reset_ctrl_checker
	import rcw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire rcw_sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic rst_pin_in,
	input wire logic rst_pin_out,
	input wire logic rst_pin_oe,
	input wire logic sys_rst_b
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Clocks with the pin released while the core is still held.
	logic [4:0] free_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			free_q <= 5'h00;
		end else if (sys_rst_b || !rst_pin_in) begin
			free_q <= 5'h00;
		end else if (free_q != 5'h1F) begin
			free_q <= free_q + 5'h01;
		end
	end
	// An accepted write to the reset cause register with a bit of m set.
	sequence s_rc_wr(m);
		sys_rst_b && sfr_req.wr && sfr_req.addr == 8'hEF && (sfr_req.wdata & m) != 8'h00;
	endsequence
	AST_PIN_OPEN_DRAIN: assert property (rst_pin_oe |-> !rst_pin_out)
		else $error("reset pin driven high");
	AST_SW_RESET: assert property (s_rc_wr(8'h10) |-> ##[1:3] !sys_rst_b)
		else $error("software reset not entered");
	AST_SW_NO_PIN: assert property ((!rst_pin_oe && !sfr_req.wdata[0]) ##0 s_rc_wr(8'h10) |-> !rst_pin_oe [*8])
		else $error("software reset drove the pin");
	AST_PIN_FORCE: assert property (s_rc_wr(8'h01) |-> ##[1:3] rst_pin_oe)
		else $error("pin reset did not drive the pin");
	AST_STRETCH: assert property ($rose(sys_rst_b) |-> free_q >= 5'h0C)
		else $error("reset released too early");
	AST_WD_READ: assert property (sfr_req.rd && sfr_req.addr == 8'hFF |-> ##2 (sfr_rdata & 8'hE8) == 8'h00)
		else $error("watchdog read has stray bits");
	AST_RC_RESERVED: assert property (sfr_req.rd && sfr_req.addr == 8'hEF |-> ##2 !sfr_rdata[7])
		else $error("reserved cause bit set");
	AST_UNMAPPED: assert property (sfr_req.rd && sfr_req.addr != 8'hEF && sfr_req.addr != 8'hFF |-> ##2 sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule

bind rcw_reset_ctrl rcw_reset_ctrl_checker i_rcw_reset_ctrl_checker (
	.clk(clk),
	.rst_b(rst_b),
	.sfr_req(sfr_req),
	.sfr_rdata(sfr_rdata),
	.rst_pin_in(rst_pin_in),
	.rst_pin_out(rst_pin_out),
	.rst_pin_oe(rst_pin_oe),
	.sys_rst_b(sys_rst_b)
);

// >>> sim/tb.sv
`timescale 1ns/10ps
// Self-checking bench; a small model tracks the watchdog register.
module tb
	import rcw_pkg::*;
;
	logic clk, rst_b, pin_ext, smt, sme, pin_out, pin_oe, sys_b, s;
	logic [2:0] src;
	logic [7:0] rdata, r;
	rcw_sfr_req_t req;
	int num_errors, compares, seed, m_run, m_intv, m_lock, m_de, n1, n2;
	time m_de_t;
	// Pulled-up pin, low when either party pulls it.
	wire pin_in = pin_ext & !pin_oe;
	rcw_reset_ctrl #(.WDOG_BASE_LOG2(1)) i_rcw_reset_ctrl (
		.clk(clk),
		.rst_b(rst_b),
		.sfr_req(req),
		.sfr_rdata(rdata),
		.rst_pin_in(pin_in),
		.rst_pin_out(pin_out),
		.rst_pin_oe(pin_oe),
		.convert_start_input(!src[2]),
		.first_comparator(!src[1]),
		.missing_clock_trip(src[0]),
		.supply_monitor_trip(smt),
		.supply_monitor_enable_pin(sme),
		.sys_rst_b(sys_b)
	);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Cuts a hung run short.
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		$display("Error at %0t run limit", $time);
		finish_test();
	end
	task finish_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Expected watchdog control read value.
	function logic [7:0] wd();
		return {3'h0, m_run[0], 1'b0, m_intv[2:0]};
	endfunction
	task m_reset();
		m_run = 1;
		m_intv = 7;
		m_lock = 0;
		m_de = 0;
	endtask
	// One register write; the model follows watchdog commands.
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
		if (a == 8'hFF) begin
			if (d == 8'hA5) m_run = 1;
			if (d == 8'hFF) m_lock = 1;
			if (d == 8'hAD && m_de == 1 && m_lock == 0 && $time - m_de_t <= 400) m_run = 0;
			if (!d[7]) m_intv = d[2:0];
			m_de = (d == 8'hDE);
			m_de_t = $time;
		end
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		#1;
		chk(rdata, exp);
	endtask
	// Bounded wait for the system reset level; notes any pin drive.
	task wait_sys(input logic lvl, output logic saw, output int n);
		saw = 1'b0;
		#1;
		for (n = 0; n < 300 && sys_b !== lvl; n++) begin
			@(posedge clk);
			#1;
			saw = saw | pin_oe;
		end
		chk(8'(sys_b), 8'(lvl));
		if (sys_b !== lvl) finish_test();
	endtask
	// Waits through one reset, releases all sources, checks pin and cause.
	task got_reset(input logic exp_oe, input logic [7:0] flags, output int n);
		logic s0, s1;
		int m;
		wait_sys(1'b0, s0, n);
		src <= 3'h0;
		smt <= 1'b0;
		pin_ext <= 1'b1;
		wait_sys(1'b1, s1, m);
		m_reset();
		chk(8'(s0 | s1), 8'(exp_oe));
		rchk(8'hEF, flags);
	endtask
	task quiet();
		repeat (6) @(posedge clk);
		#1;
		chk(8'(sys_b), 8'h01);
	endtask
	initial begin
		seed = 32'h6437;
		req = '0;
		rst_b = 1'b0;
		pin_ext = 1'b1;
		src = 3'h0;
		smt = 1'b0;
		sme = 1'b1;
		m_reset();
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		wait_sys(1'b1, s, n1);
		rchk(8'hEF, 8'h02);
		rchk(8'hFF, wd());
		r = 8'($random(seed));
		rchk({1'b0, r[6:0]}, 8'h00);
		$display("test power_on done");
		wr(8'hFF, 8'hDE);
		wr(8'hFF, 8'hAD);
		rchk(8'hFF, wd());
		r = 8'($random(seed));
		wr(8'hFF, {1'b0, r[6:0]});
		rchk(8'hFF, wd());
		wr(8'hFF, 8'h07);
		wr(8'hFF, 8'hA5);
		rchk(8'hFF, wd());
		wr(8'hFF, 8'hDE);
		repeat (3) @(posedge clk);
		wr(8'hFF, 8'hAD);
		rchk(8'hFF, wd());
		// Second byte on the fourth clock after the first still disables.
		wr(8'hFF, 8'hDE);
		repeat (2) @(posedge clk);
		wr(8'hFF, 8'hAD);
		rchk(8'hFF, wd());
		wr(8'hFF, 8'hA5);
		wr(8'hFF, 8'hFF);
		wr(8'hFF, 8'hDE);
		wr(8'hFF, 8'hAD);
		rchk(8'hFF, wd());
		for (int i = 1; i < 3; i++) begin
			wr(8'hFF, 8'hA5);
			wr(8'hFF, 8'(i));
			got_reset(1'b0, 8'h08, n2);
			if (i == 1) n1 = n2;
			rchk(8'hFF, wd());
		end
		chk(8'(n2 - n1), 8'h18);
		wr(8'hFF, 8'hDE);
		wr(8'hFF, 8'hAD);
		rchk(8'hFF, wd());
		$display("test watchdog done");
		wr(8'hEF, 8'h10);
		got_reset(1'b0, 8'h10, n1);
		wr(8'hEF, 8'h01);
		got_reset(1'b1, 8'h02, n1);
		pin_ext <= 1'b0;
		got_reset(1'b0, 8'h01, n1);
		for (int k = 0; k < 3; k++) begin
			r = (k == 2) ? 8'h40 : (k == 1) ? 8'h20 : 8'h04;
			wr(8'hEF, r | 8'h02);
			src[k] <= 1'b1;
			got_reset(1'b0, r, n1);
			src[k] <= 1'b1;
			quiet();
			src[k] <= 1'b0;
		end
		$display("test reset_sources done");
		smt <= 1'b1;
		got_reset(1'b1, 8'h02, n1);
		wr(8'hEF, 8'h00);
		smt <= 1'b1;
		quiet();
		// With the enable pin low the monitor is ignored and so is its select write.
		sme <= 1'b0;
		wr(8'hEF, 8'h02);
		quiet();
		sme <= 1'b1;
		quiet();
		smt <= 1'b0;
		$display("test supply_monitor done");
		finish_test();
	end
endmodule
